// ==== hw/srp_top.sv ====
// serial register port: serial link engine, register file and auxiliary outputs
// assumes serial_clk comes from the host and may stop while port_select_n is high
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_top #(
    parameter logic [7:0] REVISION = 8'h01 // value arbitrary
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic port_select_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_line,
    output logic serial_out_oe,
    input wire logic lsb_first,
    input wire logic three_wire_option,
    input wire logic [7:0] aux_word_a,
    input wire logic [7:0] aux_word_b,
    input wire logic [7:0] aux_word_c,
    output logic [2:0] aux_shutdown,
    output logic [7:0] aux_eff_a,
    output logic [7:0] aux_eff_b,
    output logic [7:0] aux_eff_c,
    output logic [11:0] level_word,
    output logic sd_out,
    output logic [7:0] rx_bias_a,
    output logic [7:0] rx_bias_b
);
    import srp_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] bit_order(input logic [7:0] b, input logic lsb);
        logic [7:0] r;
        r = b;
        if (lsb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = b[7-i];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] wsel(input logic [7:0] cur, input logic [5:0] ofs,
                                        input logic ev, input srp_wr_t w);
        logic [5:0] a2;
        a2 = w.lsb ? w.addr + 6'h01 : w.addr - 6'h01;
        if (ev && w.addr == ofs) begin
            return w.d0;
        end else if (ev && w.two && a2 == ofs) begin
            return w.d1;
        end
        return cur;
    endfunction

    // ****************************************
    // serial clock domain: bit counter and header
    // ****************************************
    logic link_clr_n;
    logic [1:0] cfg_s;
    logic [4:0] cnt_r;
    logic [15:0] sh_r;
    logic [7:0] hdr_r;
    logic [7:0] in_byte;
    logic lsb_s;
    logic tw_s;

    // select high acts as an asynchronous clear of the frame state
    assign link_clr_n = rst_n & ~port_select_n;

    srp_sync #(.W(2)) u_cfg_sync (
        .clk(serial_clk),
        .rst_n(rst_n),
        .d({lsb_first, three_wire_option}),
        .q(cfg_s)
    );

    // config settles during the first header bits, long before it is used
    assign lsb_s = cfg_s[`SRP_CFG_LSB];
    assign tw_s = cfg_s[`SRP_CFG_TW];
    assign in_byte = {sh_r[6:0], sdio_in};

    always_ff @(posedge serial_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            cnt_r <= 5'd0;
        end else if (cnt_r != `SRP_CNT_SAT) begin
            cnt_r <= cnt_r + 5'd1;
        end
    end

    always_ff @(posedge serial_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            sh_r <= 16'h0000;
        end else begin
            sh_r <= {sh_r[14:0], sdio_in};
        end
    end

    always_ff @(posedge serial_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            hdr_r <= 8'h00;
        end else if (cnt_r == `SRP_CNT_HDR_LAST) begin
            hdr_r <= bit_order(in_byte, lsb_s);
        end
    end

    // ****************************************
    // serial clock domain: write capture
    // ****************************************
    srp_wr_t wr_r;
    logic wr_tog_r;

    // only an exact bit count commits, so a cut-short write never toggles
    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            wr_tog_r <= 1'b0;
        end else if (!hdr_r[`SRP_HDR_RW]) begin
            if (!hdr_r[`SRP_HDR_TWO] && cnt_r == `SRP_CNT_ONE_LAST) begin
                wr_r.addr <= hdr_r[5:0];
                wr_r.two <= 1'b0;
                wr_r.lsb <= lsb_s;
                wr_r.d0 <= bit_order(in_byte, lsb_s);
                wr_r.d1 <= 8'h00;
                wr_tog_r <= ~wr_tog_r;
            end else if (hdr_r[`SRP_HDR_TWO] && cnt_r == `SRP_CNT_TWO_LAST) begin
                wr_r.addr <= hdr_r[5:0];
                wr_r.two <= 1'b1;
                wr_r.lsb <= lsb_s;
                wr_r.d0 <= bit_order(sh_r[14:7], lsb_s);
                wr_r.d1 <= bit_order(in_byte, lsb_s);
                wr_tog_r <= ~wr_tog_r;
            end
        end
    end

    // ****************************************
    // serial clock domain: read drive
    // ****************************************
    logic [7:0] rd_data;
    logic rd_phase;
    logic rd_bit;
    logic [2:0] rd_idx;

    // read phase spans the 8 falling edges after the header
    assign rd_phase = hdr_r[`SRP_HDR_RW] && cnt_r[4:3] == 2'b01;
    assign rd_idx = cnt_r[2:0];
    assign rd_bit = lsb_s ? rd_data[rd_idx] : rd_data[3'd7 - rd_idx];

    always_ff @(negedge serial_clk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            serial_out_line <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            sdio_out <= rd_phase & rd_bit;
            sdio_oe <= rd_phase & tw_s;
            serial_out_line <= rd_phase & rd_bit;
            serial_out_oe <= rd_phase & ~tw_s;
        end
    end

    // ****************************************
    // core clock domain: commit handshake
    // ****************************************
    logic wr_tog_s;
    logic wr_tog_d_r;
    logic commit;

    // write words are held still from the toggle until the next commit
    srp_sync #(.W(1)) u_tog_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(wr_tog_r),
        .q(wr_tog_s)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_tog_d_r <= 1'b0;
        end else begin
            wr_tog_d_r <= wr_tog_s;
        end
    end

    assign commit = wr_tog_s ^ wr_tog_d_r;

    // ****************************************
    // core clock domain: register file
    // ****************************************
    logic [7:0] shutdown_r;
    logic [7:0] polarity_r;
    logic [7:0] level_a_r;
    logic [7:0] level_b_full;
    logic [3:0] level_b_r;

    assign level_b_full = wsel({4'h0, level_b_r}, `SRP_OFS_LEVEL_B, commit, wr_r);

    // revision and unmapped addresses have no store, so writes fall away
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown_r <= `SRP_RST_REG;
            polarity_r <= `SRP_RST_REG;
        end else begin
            shutdown_r <= wsel(shutdown_r, `SRP_OFS_SHUTDOWN, commit, wr_r);
            polarity_r <= wsel(polarity_r, `SRP_OFS_POLARITY, commit, wr_r);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_a_r <= `SRP_RST_REG;
            level_b_r <= 4'h0;
        end else begin
            level_a_r <= wsel(level_a_r, `SRP_OFS_LEVEL_A, commit, wr_r);
            level_b_r <= level_b_full[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_bias_a <= `SRP_RST_REG;
            rx_bias_b <= `SRP_RST_REG;
        end else begin
            rx_bias_a <= wsel(rx_bias_a, `SRP_OFS_BIAS_A, commit, wr_r);
            rx_bias_b <= wsel(rx_bias_b, `SRP_OFS_BIAS_B, commit, wr_r);
        end
    end

    assign aux_shutdown = shutdown_r[2:0];
    assign level_word = {level_a_r, level_b_r};

    // ****************************************
    // read mux
    // ****************************************
    // registers only change through this port, so they are still during a read
    always_comb begin
        unique case (hdr_r[5:0])
            `SRP_OFS_SHUTDOWN: rd_data = shutdown_r;
            `SRP_OFS_POLARITY: rd_data = polarity_r;
            `SRP_OFS_LEVEL_A: rd_data = level_a_r;
            `SRP_OFS_LEVEL_B: rd_data = {4'h0, level_b_r};
            `SRP_OFS_BIAS_A: rd_data = rx_bias_a;
            `SRP_OFS_BIAS_B: rd_data = rx_bias_b;
            `SRP_OFS_REVISION: rd_data = REVISION;
            default: rd_data = 8'h00;
        endcase
    end

    // ****************************************
    // auxiliary outputs
    // ****************************************
    srp_sigma u_sigma (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level_word(level_word),
        .polarity(polarity_r),
        .aux_word_a(aux_word_a),
        .aux_word_b(aux_word_b),
        .aux_word_c(aux_word_c),
        .sd_out(sd_out),
        .aux_eff_a(aux_eff_a),
        .aux_eff_b(aux_eff_b),
        .aux_eff_c(aux_eff_c)
    );

    // ****************************************
    // checks
    // ****************************************
    property p_idle_float;
        @(posedge core_clk) disable iff (!rst_n)
        port_select_n |-> cnt_r == 5'd0 && !sdio_oe && !serial_out_oe;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("drive or count while idle");
    property p_commit_count;
        @(posedge serial_clk) disable iff (!rst_n)
        wr_tog_r != $past(wr_tog_r) |-> !$past(hdr_r[7])
            && ($past(cnt_r) == `SRP_CNT_ONE_LAST || $past(cnt_r) == `SRP_CNT_TWO_LAST);
    endproperty
    a_commit_count: assert property (p_commit_count) else $error("commit at wrong bit");
    property p_one_line;
        @(posedge serial_clk) disable iff (!rst_n)
        !(sdio_oe && serial_out_oe);
    endproperty
    a_one_line: assert property (p_one_line) else $error("both outputs driven");
    property p_read_window;
        @(posedge serial_clk) disable iff (!rst_n)
        (sdio_oe || serial_out_oe) |-> hdr_r[7] && cnt_r >= 5'd8 && cnt_r <= 5'd15;
    endproperty
    a_read_window: assert property (p_read_window) else $error("drive outside read");
    property p_read_len;
        @(posedge serial_clk) disable iff (!rst_n || port_select_n)
        $rose(serial_out_oe) |-> serial_out_oe[*8] ##1 !serial_out_oe;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read not eight bits");
    property p_shutdown_wr;
        @(posedge core_clk) disable iff (!rst_n)
        commit && !wr_r.two && wr_r.addr == `SRP_OFS_SHUTDOWN
            |=> aux_shutdown == $past(wr_r.d0[2:0]);
    endproperty
    a_shutdown_wr: assert property (p_shutdown_wr) else $error("shutdown not stored");
    property p_second_byte;
        @(posedge core_clk) disable iff (!rst_n)
        commit && wr_r.two && !wr_r.lsb && wr_r.addr == `SRP_OFS_LEVEL_B
            |=> level_a_r == $past(wr_r.d1) && level_b_r == $past(wr_r.d0[3:0]);
    endproperty
    a_second_byte: assert property (p_second_byte) else $error("two-byte order wrong");
    property p_rev_ro;
        @(posedge core_clk) disable iff (!rst_n)
        commit && !wr_r.two && wr_r.addr == `SRP_OFS_REVISION
            |=> $stable(shutdown_r) && $stable(polarity_r) && $stable(level_word)
                && $stable(rx_bias_a) && $stable(rx_bias_b);
    endproperty
    a_rev_ro: assert property (p_rev_ro) else $error("revision write changed state");
endmodule

// ==== hw/srp_defs.svh ====
// register offsets, field positions, reset values and bit counts of the serial register port
// assumes a 6-bit register address and 8-bit registers
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define SRP_OFS_SHUTDOWN 6'h28
`define SRP_OFS_POLARITY 6'h29
`define SRP_OFS_LEVEL_A 6'h2A
`define SRP_OFS_LEVEL_B 6'h2B
`define SRP_OFS_BIAS_A 6'h31
`define SRP_OFS_BIAS_B 6'h32
`define SRP_OFS_REVISION 6'h3F

// ****************************************
// reset values
// ****************************************
`define SRP_RST_REG 8'h00
`define SRP_RST_LEVEL 12'h000

// ****************************************
// field positions
// ****************************************
`define SRP_HDR_RW 7
`define SRP_HDR_TWO 6
`define SRP_PD_C 2
`define SRP_PD_B 1
`define SRP_PD_A 0
`define SRP_INV_C 4
`define SRP_INV_B 2
`define SRP_INV_A 0
`define SRP_CFG_LSB 1
`define SRP_CFG_TW 0

// ****************************************
// serial bit counts (rising edges seen so far)
// ****************************************
`define SRP_CNT_HDR_LAST 5'd7
`define SRP_CNT_ONE_LAST 5'd15
`define SRP_CNT_TWO_LAST 5'd23
`define SRP_CNT_SAT 5'd24

`endif

// ==== hw/srp_pkg.sv ====
// types shared by the serial register port
// assumes nothing beyond the constants header
package srp_pkg;
    // one committed write, handed from the serial clock to the core clock
    typedef struct packed {
        logic [5:0] addr;
        logic two;
        logic lsb;
        logic [7:0] d0;
        logic [7:0] d1;
    } srp_wr_t;
endpackage

// ==== hw/srp_sync.sv ====
// two-flop synchroniser for level signals
// assumes each bit is a level that stays put for several destination clocks
`timescale 1ns/1ps
module srp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== hw/srp_sigma.sv ====
// sigma-delta level output and auxiliary converter word decoding
// assumes level and polarity come from flops in the core clock domain
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_sigma (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] level_word,
    input wire logic [7:0] polarity,
    input wire logic [7:0] aux_word_a,
    input wire logic [7:0] aux_word_b,
    input wire logic [7:0] aux_word_c,
    output logic sd_out,
    output logic [7:0] aux_eff_a,
    output logic [7:0] aux_eff_b,
    output logic [7:0] aux_eff_c
);
    logic [11:0] acc_r;
    logic [12:0] sum;

    // ****************************************
    // first-order modulator: carry density tracks the level word
    // ****************************************
    assign sum = {1'b0, acc_r} + {1'b0, level_word};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 12'h000;
            sd_out <= 1'b0;
        end else begin
            acc_r <= sum[11:0];
            sd_out <= sum[12];
        end
    end

    // ****************************************
    // word inversion per polarity bit
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_eff_a <= 8'h00;
            aux_eff_b <= 8'h00;
            aux_eff_c <= 8'h00;
        end else begin
            aux_eff_a <= aux_word_a ^ {8{polarity[`SRP_INV_A]}};
            aux_eff_b <= aux_word_b ^ {8{polarity[`SRP_INV_B]}};
            aux_eff_c <= aux_word_c ^ {8{polarity[`SRP_INV_C]}};
        end
    end

    property p_inv_c;
        @(posedge core_clk) disable iff (!rst_n)
        polarity[`SRP_INV_C] |=> aux_eff_c == ~$past(aux_word_c);
    endproperty
    a_inv_c: assert property (p_inv_c) else $error("word c not inverted");

    property p_sd_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (level_word == 12'h000)[*8] |-> !sd_out;
    endproperty
    a_sd_zero: assert property (p_sd_zero) else $error("zero level gives output pulses");
endmodule

// ==== bench/srp_host_model.sv ====
// host controller model for the serial register port
// assumes one frame at a time, called from the bench; device data outputs fed back here
`timescale 1ns/1ps
module srp_host_model (
    output logic serial_clk,
    output logic port_select_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_out_line,
    input wire logic serial_out_oe
);
    logic drv;
    logic bit_r;
    // released line shows the inverse of the last bit, never a held value
    assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_r : ~bit_r);
    initial begin
        serial_clk = 1'b0;
        port_select_n = 1'b1;
        drv = 1'b1;
        bit_r = 1'b0;
    end
    // ****************************************
    // frame: header w[23:16], data w[15:8] then w[7:0], n rising edges
    // ****************************************
    task automatic frame(input logic [23:0] w, input int n, input logic lsb, input logic tw,
                         output logic [7:0] rd, output logic ok);
        int k;
        int p;
        rd = 8'h00;
        ok = 1'b1;
        #43;
        port_select_n = 1'b0;
        for (k = 0; k < n; k++) begin
            p = lsb ? k % 8 : 7 - k % 8;
            drv = !(w[23] && tw && k >= 8);
            if (drv) begin
                bit_r = w[(2 - k / 8) * 8 + p];
            end
            #80;
            serial_clk = 1'b1;
            if (w[23] && k >= 8) begin
                rd[lsb ? k - 8 : 15 - k] = tw ? sdio_in : serial_out_line;
                ok = ok & (tw ? sdio_oe & ~serial_out_oe : serial_out_oe & ~sdio_oe);
            end
            #80;
            serial_clk = 1'b0;
        end
        #40;
        port_select_n = 1'b1;
        drv = 1'b1;
        #160;
    endtask
endmodule

// ==== bench/srp_top_tb.sv ====
// self-checking bench for the serial register port
// assumes srp_host_model plays the host; registers reached only over the serial link
`timescale 1ns/1ps
module srp_top_tb;
    localparam logic [7:0] REV = 8'h5A; // value arbitrary
    logic core_clk;
    logic rst_n;
    logic lsb_first;
    logic three_wire_option;
    logic [7:0] aux_word_a;
    logic [7:0] aux_word_b;
    logic [7:0] aux_word_c;
    logic serial_clk;
    logic port_select_n;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic serial_out_line;
    logic serial_out_oe;
    logic [2:0] aux_shutdown;
    logic [7:0] aux_eff_a;
    logic [7:0] aux_eff_b;
    logic [7:0] aux_eff_c;
    logic [11:0] level_word;
    logic sd_out;
    logic [7:0] rx_bias_a;
    logic [7:0] rx_bias_b;
    logic [7:0] rd;
    logic ok;
    int ones;
    int mismatches;
    int total_checks;

    srp_top #(.REVISION(REV)) srp_top_i (
        .core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk),
        .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
        .lsb_first(lsb_first), .three_wire_option(three_wire_option),
        .aux_word_a(aux_word_a), .aux_word_b(aux_word_b), .aux_word_c(aux_word_c),
        .aux_shutdown(aux_shutdown), .aux_eff_a(aux_eff_a), .aux_eff_b(aux_eff_b),
        .aux_eff_c(aux_eff_c), .level_word(level_word), .sd_out(sd_out),
        .rx_bias_a(rx_bias_a), .rx_bias_b(rx_bias_b)
    );

    srp_host_model srp_host_model_i (
        .serial_clk(serial_clk), .port_select_n(port_select_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe)
    );

    always #4 core_clk = ~core_clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // commits land within a few core cycles of the last rising edge
    task automatic xfer(input logic [23:0] w, input int n);
        srp_host_model_i.frame(w, n, lsb_first, three_wire_option, rd, ok);
        repeat (10) @(posedge core_clk);
    endtask

    task automatic wr1(input logic [5:0] a, input logic [7:0] d);
        xfer({2'b00, a, d, 8'h00}, 16);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        xfer({2'b10, a, 16'h0000}, 16);
        check("read_data", 32'(rd), 32'(exp));
        check("read_drive", 32'(ok), 32'h1);
        check("oe_idle", 32'({sdio_oe, serial_out_oe}), 32'h0);
    endtask

    task automatic set_mode(input logic l, input logic t);
        @(posedge core_clk);
        lsb_first <= l;
        three_wire_option <= t;
        repeat (4) @(posedge core_clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_reset();
        check("shutdown", 32'(aux_shutdown), 32'h0);
        check("level", 32'(level_word), 32'h0);
        check("bias", 32'({rx_bias_a, rx_bias_b}), 32'h0);
        check("eff", 32'({aux_eff_a, aux_eff_b, aux_eff_c}), 32'h3C81F0);
        repeat (40) begin
            @(negedge core_clk);
            check("sd_idle", 32'(sd_out), 32'h0);
        end
        rd_chk(6'h3F, REV);
        rd_chk(6'h10, 8'h00);
    endtask

    task automatic s_shutdown();
        int i;
        for (i = 0; i < 3; i++) begin
            wr1(6'h28, 8'(1 << i));
            check("shutdown", 32'(aux_shutdown), 32'(1 << i));
        end
        rd_chk(6'h28, 8'h04);
        wr1(6'h28, 8'h00);
    endtask

    task automatic s_polarity();
        wr1(6'h29, 8'h15);
        check("eff", 32'({aux_eff_a, aux_eff_b, aux_eff_c}), 32'hC37E0F);
        wr1(6'h29, 8'h04);
        check("eff", 32'({aux_eff_a, aux_eff_b, aux_eff_c}), 32'h3C7EF0);
    endtask

    task automatic s_level();
        xfer({2'b01, 6'h2B, 8'hF7, 8'hAB}, 24);
        check("level", 32'(level_word), 32'hAB7);
        rd_chk(6'h2B, 8'h07);
        rd_chk(6'h2A, 8'hAB);
        ones = 0;
        repeat (4096) begin
            @(negedge core_clk);
            ones += int'(sd_out);
        end
        check("sd_density", 32'(ones > 2741 && ones < 2745), 32'h1);
    endtask

    task automatic s_lsb_bias();
        set_mode(1'b1, 1'b0);
        xfer({2'b01, 6'h31, 8'h03, 8'hEC}, 24);
        check("bias", 32'({rx_bias_a, rx_bias_b}), 32'h03EC);
        rd_chk(6'h32, 8'hEC);
        wr1(6'h32, 8'h9E);
        check("bias_b", 32'(rx_bias_b), 32'h9E);
    endtask

    task automatic s_abort_ro();
        xfer({2'b00, 6'h32, 8'h55, 8'h00}, 15);
        xfer({2'b01, 6'h28, 8'h07, 8'h07}, 23);
        check("bias_b", 32'(rx_bias_b), 32'h9E);
        check("shutdown", 32'(aux_shutdown), 32'h0);
        set_mode(1'b0, 1'b0);
        wr1(6'h3F, 8'hFF);
        rd_chk(6'h3F, REV);
    endtask

    task automatic s_three_wire();
        set_mode(1'b0, 1'b1);
        rd_chk(6'h31, 8'h03);
        xfer({2'b10, 6'h31, 16'h0000}, 12);
        check("oe_cut", 32'({sdio_oe, serial_out_oe}), 32'h0);
        set_mode(1'b1, 1'b1);
        rd_chk(6'h2A, 8'hAB);
        set_mode(1'b0, 1'b0);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        lsb_first = 1'b0;
        three_wire_option = 1'b0;
        aux_word_a = 8'h3C;
        aux_word_b = 8'h81;
        aux_word_c = 8'hF0;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        s_reset();
        s_shutdown();
        s_polarity();
        s_level();
        s_lsb_bias();
        s_abort_ro();
        s_three_wire();
        complete_run();
    end
endmodule
